/* logic/cms_params.svh */
`ifndef CMS_PARAMS_SVH
`define CMS_PARAMS_SVH

// Register bus widths.
`define CMS_ADDR_W        8
`define CMS_DATA_W        32

// Register byte offsets.
`define CMS_OFS_MODE      8'h00
`define CMS_OFS_RESULT    8'h04
`define CMS_OFS_CHAN      8'h08

// Reset values.
`define CMS_MODE_RST      2'h0
`define CMS_CHAN_RST      32'h0000_0000

// Layout of the search result word.
`define CMS_RES_IDX_LSB   0
`define CMS_RES_IDX_W     6
`define CMS_RES_EXH_BIT   8

// Mailbox map.
`define CMS_MB_NUM        64
`define CMS_TXF_FIRST     56
`define CMS_TXF_LAST      59
`define CMS_RXF_FIRST     60
`define CMS_RXF_LAST      63
`define CMS_FIFO_SPAN     8

// Width of the channel search vector.
`define CMS_CHAN_W        16

`endif

/* logic/cms_pkg.sv */
`include "cms_params.svh"

package cms_pkg;

  // Search mode selector encodings.
  typedef enum logic [1:0]
  {
    CMS_MODE_RX   = 2'b00,
    CMS_MODE_TX   = 2'b01,
    CMS_MODE_LOST = 2'b10,
    CMS_MODE_CHAN = 2'b11
  } cms_mode_t;

  // One register bus request from software.
  typedef struct packed
  {
    logic [`CMS_ADDR_W-1:0] addr;
    logic [`CMS_DATA_W-1:0] wdata;
    logic                   wr;
    logic                   rd;
  } cms_bus_req_t;

  // Per-mailbox flags from the message engine.
  typedef struct packed
  {
    logic [`CMS_MB_NUM-1:0] rx;
    logic [`CMS_MB_NUM-1:0] tx;
    logic [`CMS_MB_NUM-1:0] lost;
  } cms_mb_flags_t;

endpackage

/* logic/cms_lowest_set.sv */
`timescale 1ns/100ps

module cms_lowest_set
#(
  parameter int N  = 64,
  parameter int IW = 6
)
(
  // Candidate bits.
  input  wire logic [N-1:0]  vec,
  // Search answer.
  output logic               found,
  output logic [IW-1:0]      idx
);

  logic [N:0]    seen;
  logic [IW-1:0] acc [0:N];

  // The chain runs from bit 0 upward so the lowest set bit wins.
  assign seen[0] = 1'b0;
  assign acc[0]  = '0;

  for (genvar i = 0; i < N; i++)
  begin : g_bit
    assign seen[i+1] = seen[i] | vec[i];
    assign acc[i+1]  = acc[i] | ((vec[i] & ~seen[i]) ? IW'(i) : '0);
  end

  assign found = seen[N];
  assign idx   = acc[N];

endmodule

/* logic/cms_chan_vec.sv */
`timescale 1ns/100ps
`include "cms_params.svh"

module cms_chan_vec
#(
  parameter int W  = 16,
  parameter int IW = 4
)
(
  // Clock and reset.
  input  wire logic          sys_clk,
  input  wire logic          rstn,
  // Software load and consume strobes.
  input  wire logic          load,
  input  wire logic [W-1:0]  load_val,
  input  wire logic          consume,
  // Vector state and its lowest set bit.
  output logic [W-1:0]       vec_r,
  output logic               found,
  output logic [IW-1:0]      idx
);

  logic [W-1:0] vec_nxt;

  // Each consume drops only the lowest set bit, so reads walk upward.
  always_comb
  begin
    vec_nxt = vec_r;
    if (load)
      vec_nxt = load_val;
    else if (consume)
      vec_nxt = vec_r & (vec_r - W'(1));
  end

  // Vector register.
  always_ff @(posedge sys_clk)
  begin
    if (!rstn)
      vec_r <= W'(`CMS_CHAN_RST);
    else
      vec_r <= vec_nxt;
  end

  cms_lowest_set #(.N(W), .IW(IW)) u_enc
  (
    .vec   (vec_r),
    .found (found),
    .idx   (idx)
  );

  //////////////////////////////////////////////////////////////////////////////

  // Checks on the channel vector.
  a_chan_load_value: assert property (@(posedge sys_clk) disable iff (!rstn)
    load |=> vec_r == $past(load_val))
    else $error("Channel vector did not take the written value.");

  a_chan_read_advance: assert property (@(posedge sys_clk) disable iff (!rstn)
    (consume && !load && vec_r != '0) |=> $countones(vec_r) == $countones($past(vec_r)) - 1
      && (vec_r & ~$past(vec_r)) == '0)
    else $error("Channel read did not drop exactly one set bit.");

  c_chan_drained: cover property (@(posedge sys_clk) disable iff (!rstn)
    consume && $countones(vec_r) == 1 ##1 vec_r == '0);

endmodule

/* logic/cms_search_top.sv */
// Our own choices: the address map and the plain strobed port.
`timescale 1ns/100ps
`include "cms_params.svh"

// Notes on behaviour
// - Two-bit selector picks rx, tx, lost, channel
// - Receive search returns lowest pending mailbox
// - No searched flag set means exhausted bit one
// - FIFO mode: unread receive FIFO reports 60
// - Transmit search returns lowest completed mailbox
// - FIFO mode transmit search skips transmit FIFO
// - FIFO mode lost search includes receive FIFO lost flag
// - FIFO mode: FIFO lost flag reports 60
// - Software loads vector; lowest set bit returned
// - Channel reads advance; empty sets exhausted bit
// - FIFO mode: 56-59 transmit, 60-63 receive FIFO
// - All modes work in both mailbox modes

module cms_search_top
#(
  parameter int CHAN_W = `CMS_CHAN_W
)
(
  // Clock and reset.
  input  wire logic                    sys_clk,
  input  wire logic                    rstn,
  // Register port.
  input  wire cms_pkg::cms_bus_req_t   bus_req,
  output logic [`CMS_DATA_W-1:0]       rd_data,
  // Mailbox flags from the message engine.
  input  wire cms_pkg::cms_mb_flags_t  mb_flags,
  input  wire logic                    rx_fifo_empty_flag,
  input  wire logic                    rx_fifo_lost_flag,
  input  wire logic                    fifo_mailbox_mode_bit,
  // Live search state.
  output logic                         search_exhausted_bit,
  output cms_pkg::cms_mode_t           search_mode_field
);

  localparam int MB_IW   = `CMS_RES_IDX_W;
  localparam int CHAN_IW = $clog2(CHAN_W);

  cms_pkg::cms_mode_t            mode_r;
  logic [`CMS_MB_NUM-1:0]        rx_eff;
  logic [`CMS_MB_NUM-1:0]        tx_eff;
  logic [`CMS_MB_NUM-1:0]        lost_eff;
  logic [`CMS_MB_NUM-1:0]        sel_vec;
  logic                          mb_found;
  logic [MB_IW-1:0]              mb_idx;
  logic [CHAN_W-1:0]             chan_vec;
  logic                          chan_found;
  logic [CHAN_IW-1:0]            chan_idx;
  logic                          hit_mode;
  logic                          hit_result;
  logic                          hit_chan;
  logic                          wr_mode;
  logic                          wr_chan;
  logic                          rd_result;
  logic                          chan_consume;
  logic                          cur_found;
  logic [MB_IW-1:0]              cur_idx;
  logic [`CMS_DATA_W-1:0]        result_word;
  logic [`CMS_DATA_W-1:0]        rd_data_nxt;
  logic                          exhausted_nxt;

  //////////////////////////////////////////////////////////////////////////////
  // Register decode.

  // Address compares are shared by reads and writes.
  assign hit_mode   = bus_req.addr == `CMS_OFS_MODE;
  assign hit_result = bus_req.addr == `CMS_OFS_RESULT;
  assign hit_chan   = bus_req.addr == `CMS_OFS_CHAN;

  // Qualified strobes.
  assign wr_mode   = bus_req.wr & hit_mode;
  assign wr_chan   = bus_req.wr & hit_chan;
  assign rd_result = bus_req.rd & hit_result;

  // Only a channel-mode read consumes anything; mailbox reads are pure.
  assign chan_consume = rd_result & (mode_r == cms_pkg::CMS_MODE_CHAN);

  // Search mode selector.
  always_ff @(posedge sys_clk)
  begin
    if (!rstn)
      mode_r <= cms_pkg::cms_mode_t'(`CMS_MODE_RST);
    else if (wr_mode)
      mode_r <= cms_pkg::cms_mode_t'(bus_req.wdata[1:0]);
  end

  assign search_mode_field = mode_r;

  //////////////////////////////////////////////////////////////////////////////
  // Mailbox views.

  // In FIFO mode the top eight mailboxes lose their own flags; only the receive
  // FIFO head at mailbox 60 may stand for the whole receive FIFO.
  always_comb
  begin
    rx_eff   = mb_flags.rx;
    tx_eff   = mb_flags.tx;
    lost_eff = mb_flags.lost;
    if (fifo_mailbox_mode_bit)
    begin
      rx_eff[`CMS_TXF_FIRST +: `CMS_FIFO_SPAN]   = '0;
      tx_eff[`CMS_TXF_FIRST +: `CMS_FIFO_SPAN]   = '0;
      lost_eff[`CMS_TXF_FIRST +: `CMS_FIFO_SPAN] = '0;
      rx_eff[`CMS_RXF_FIRST]   = ~rx_fifo_empty_flag;
      lost_eff[`CMS_RXF_FIRST] = rx_fifo_lost_flag;
    end
  end

  // The selector decides which flag set the encoder looks at.
  always_comb
  begin
    case (mode_r)
      cms_pkg::CMS_MODE_RX:   sel_vec = rx_eff;
      cms_pkg::CMS_MODE_TX:   sel_vec = tx_eff;
      cms_pkg::CMS_MODE_LOST: sel_vec = lost_eff;
      default:                sel_vec = '0;
    endcase
  end

  // Lowest pending mailbox.
  cms_lowest_set #(.N(`CMS_MB_NUM), .IW(MB_IW)) u_mb_enc
  (
    .vec   (sel_vec),
    .found (mb_found),
    .idx   (mb_idx)
  );

  // Channel search vector with advance on read.
  cms_chan_vec #(.W(CHAN_W), .IW(CHAN_IW)) u_chan
  (
    .sys_clk  (sys_clk),
    .rstn     (rstn),
    .load     (wr_chan),
    .load_val (bus_req.wdata[CHAN_W-1:0]),
    .consume  (chan_consume),
    .vec_r    (chan_vec),
    .found    (chan_found),
    .idx      (chan_idx)
  );

  //////////////////////////////////////////////////////////////////////////////
  // Search result.

  // The answer follows the selected mode; an empty search reads index zero.
  always_comb
  begin
    if (mode_r == cms_pkg::CMS_MODE_CHAN)
    begin
      cur_found = chan_found;
      cur_idx   = MB_IW'(chan_idx);
    end
    else
    begin
      cur_found = mb_found;
      cur_idx   = mb_idx;
    end
  end

  // Result word: index in the low bits, exhausted bit above it.
  always_comb
  begin
    result_word = '0;
    result_word[`CMS_RES_IDX_LSB +: MB_IW] = cur_found ? cur_idx : '0;
    result_word[`CMS_RES_EXH_BIT]          = ~cur_found;
  end

  // Read mux; unmapped offsets read as zero.
  always_comb
  begin
    rd_data_nxt = '0;
    if (bus_req.rd)
    begin
      if (hit_mode)
        rd_data_nxt[1:0] = mode_r;
      else if (hit_result)
        rd_data_nxt = result_word;
      else if (hit_chan)
        rd_data_nxt[CHAN_W-1:0] = chan_vec;
    end
  end

  // Read data stand for exactly the cycle after the strobe.
  always_ff @(posedge sys_clk)
  begin
    if (!rstn)
      rd_data <= '0;
    else
      rd_data <= rd_data_nxt;
  end

  // The live exhausted flag lags by one cycle so it comes from a flop.
  assign exhausted_nxt = ~cur_found;

  always_ff @(posedge sys_clk)
  begin
    if (!rstn)
      search_exhausted_bit <= 1'b1;
    else
      search_exhausted_bit <= exhausted_nxt;
  end

  //////////////////////////////////////////////////////////////////////////////
  // Checks.

  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rstn);

  a_mode_write_takes: assert property (
    wr_mode |=> mode_r == cms_pkg::cms_mode_t'($past(bus_req.wdata[1:0])))
    else $error("Mode selector did not take the written code.");

  a_rx_result_flagged: assert property (
    (rd_result && mode_r == cms_pkg::CMS_MODE_RX && mb_found)
      |=> $past(rx_eff[mb_idx]) && rd_data[`CMS_RES_EXH_BIT] == 1'b0)
    else $error("Receive search result names a mailbox without a pending flag.");

  a_lowest_wins: assert property (
    (mode_r == cms_pkg::CMS_MODE_TX && mb_found)
      |-> (tx_eff & ((64'h0000_0000_0000_0001 << mb_idx) - 64'h0000_0000_0000_0001)) == '0)
    else $error("Transmit search skipped a lower completed mailbox.");

  a_exhaust_reported: assert property (
    (rd_result && mode_r != cms_pkg::CMS_MODE_CHAN)
      |=> rd_data[`CMS_RES_EXH_BIT] == ($past(sel_vec) == '0))
    else $error("Exhausted bit disagrees with the pending flags.");

  a_fifo_rx_head: assert property (
    (fifo_mailbox_mode_bit && mode_r == cms_pkg::CMS_MODE_RX && !rx_fifo_empty_flag
      && mb_flags.rx[`CMS_TXF_FIRST-1:0] == '0) |-> mb_found && mb_idx == MB_IW'(`CMS_RXF_FIRST))
    else $error("Unread receive FIFO not reported as mailbox 60.");

  a_fifo_tx_skipped: assert property (
    (fifo_mailbox_mode_bit && mode_r == cms_pkg::CMS_MODE_TX
      && mb_flags.tx[`CMS_TXF_FIRST-1:0] == '0) |-> !mb_found)
    else $error("Transmit search looked into the transmit FIFO.");

  a_fifo_lost_head: assert property (
    (fifo_mailbox_mode_bit && mode_r == cms_pkg::CMS_MODE_LOST && rx_fifo_lost_flag
      && mb_flags.lost[`CMS_TXF_FIRST-1:0] == '0) |-> mb_found && mb_idx == MB_IW'(`CMS_RXF_FIRST))
    else $error("Receive FIFO loss not reported as mailbox 60.");

  a_mb_read_pure: assert property (
    (rd_result && mode_r != cms_pkg::CMS_MODE_CHAN && !bus_req.wr) |=> $stable(chan_vec))
    else $error("A mailbox search read changed search state.");

  a_exh_flop_tracks: assert property (
    (mode_r == cms_pkg::CMS_MODE_CHAN && !wr_mode && chan_vec == '0) |=> search_exhausted_bit)
    else $error("Empty channel vector did not raise the exhausted bit.");

  // Nothing below the receive answer may still be pending, or software would starve it.
  a_rx_lowest_wins: assert property (
    (mode_r == cms_pkg::CMS_MODE_RX && mb_found)
      |-> rx_eff[mb_idx] && (rx_eff & ((64'h0000_0000_0000_0001 << mb_idx) - 64'h0000_0000_0000_0001)) == '0)
    else $error("Receive search skipped a lower pending mailbox.");

  // The lost search ranks the receive FIFO head like any other mailbox.
  a_lost_lowest_wins: assert property (
    (mode_r == cms_pkg::CMS_MODE_LOST && mb_found)
      |-> lost_eff[mb_idx] && (lost_eff & ((64'h0000_0000_0000_0001 << mb_idx) - 64'h0000_0000_0000_0001)) == '0)
    else $error("Lost search skipped a lower mailbox with a lost message.");

  // The channel answer must name a set bit with no set bit below it.
  a_chan_lowest_bit: assert property (
    (mode_r == cms_pkg::CMS_MODE_CHAN && chan_found)
      |-> chan_vec[chan_idx] && (chan_vec & ((CHAN_W'(1) << chan_idx) - CHAN_W'(1))) == '0)
    else $error("Channel search did not name the lowest set bit.");

  // A drained channel vector reads as exhausted with a zero index.
  a_chan_empty_read: assert property (
    (rd_result && mode_r == cms_pkg::CMS_MODE_CHAN && chan_vec == '0)
      |=> rd_data[`CMS_RES_EXH_BIT] && rd_data[`CMS_RES_IDX_LSB +: MB_IW] == '0)
    else $error("Empty channel vector read without the exhausted bit.");

  // The live flag trails the selected flag set by exactly one cycle.
  a_exh_live_tracks: assert property (
    (mode_r != cms_pkg::CMS_MODE_CHAN)
      |=> search_exhausted_bit == ($past(sel_vec) == '0))
    else $error("Live exhausted bit disagrees with the pending flags.");

  // In FIFO mode only mailbox 60 may stand for the receive FIFO.
  a_fifo_rx_map: assert property (
    (fifo_mailbox_mode_bit && mode_r == cms_pkg::CMS_MODE_RX && mb_found)
      |-> mb_idx < MB_IW'(`CMS_TXF_FIRST) || mb_idx == MB_IW'(`CMS_RXF_FIRST))
    else $error("Receive search in FIFO mode named a FIFO mailbox other than 60.");

  // In normal mode the raw flags decide, the top eight mailboxes included.
  a_normal_raw_flags: assert property (
    (!fifo_mailbox_mode_bit && mode_r == cms_pkg::CMS_MODE_TX && mb_flags.tx != '0)
      |-> mb_found && mb_flags.tx[mb_idx])
    else $error("Normal mode transmit search missed a completed mailbox.");

  c_rx_several: cover property (
    rd_result && mode_r == cms_pkg::CMS_MODE_RX && $countones(rx_eff) > 1);

  c_fifo_lost: cover property (
    rd_result && fifo_mailbox_mode_bit && mode_r == cms_pkg::CMS_MODE_LOST && mb_idx == MB_IW'(`CMS_RXF_FIRST));

  c_chan_walk: cover property (
    chan_consume && chan_found ##1 chan_consume && chan_found);

endmodule

/* tb/cms_search_top_tb_top.sv */
`timescale 1ns/100ps
`include "cms_params.svh"

module cms_search_top_tb_top;
  localparam logic [31:0] EXH = 32'h0000_0100;

  logic                   sys_clk;
  logic                   rstn;
  cms_pkg::cms_bus_req_t  bus_req;
  logic [31:0]            rd_data;
  cms_pkg::cms_mb_flags_t mb_flags;
  logic                   rx_fifo_empty_flag;
  logic                   rx_fifo_lost_flag;
  logic                   fifo_mailbox_mode_bit;
  logic                   search_exhausted_bit;
  cms_pkg::cms_mode_t     search_mode_field;
  int                     error_cnt;
  int                     comparisons;

  ////////////////////////////////////////////////////////////////////////////
  // Device under test, with the documented channel vector width.
  cms_search_top #(.CHAN_W(16)) cms_search_top_inst
  (
    .sys_clk               (sys_clk),
    .rstn                  (rstn),
    .bus_req               (bus_req),
    .rd_data               (rd_data),
    .mb_flags              (mb_flags),
    .rx_fifo_empty_flag    (rx_fifo_empty_flag),
    .rx_fifo_lost_flag     (rx_fifo_lost_flag),
    .fifo_mailbox_mode_bit (fifo_mailbox_mode_bit),
    .search_exhausted_bit  (search_exhausted_bit),
    .search_mode_field     (search_mode_field)
  );

  // Free-running 25 MHz clock.
  always #20 sys_clk = ~sys_clk;

  ////////////////////////////////////////////////////////////////////////////
  // Compare and count; case inequality keeps unknowns from passing.
  task automatic check(string what, logic [31:0] exp, logic [31:0] got);
    comparisons++;
    if (got !== exp)
    begin
      error_cnt++;
      $display("mismatch %s expected %h seen %h", what, exp, got);
    end
  endtask

  // One-cycle write strobe, launched just after a rising edge.
  task automatic bus_wr(logic [7:0] a, logic [31:0] d);
    @(posedge sys_clk);
    bus_req.addr  <= a;
    bus_req.wdata <= d;
    bus_req.wr    <= 1'b1;
    @(posedge sys_clk);
    bus_req.wr    <= 1'b0;
  endtask

  // Read data stand only in the cycle after the strobe, so sample there.
  task automatic bus_rd(logic [7:0] a, logic [31:0] exp, string what);
    @(posedge sys_clk);
    bus_req.addr <= a;
    bus_req.rd   <= 1'b1;
    @(posedge sys_clk);
    bus_req.rd   <= 1'b0;
    #1;
    check(what, exp, rd_data);
  endtask

  // Flags change together on one edge, as the message engine would drive them.
  task automatic setf(logic [63:0] rx, tx, lost, logic fm, emp, fl);
    @(posedge sys_clk);
    mb_flags.rx           <= rx;
    mb_flags.tx           <= tx;
    mb_flags.lost         <= lost;
    fifo_mailbox_mode_bit <= fm;
    rx_fifo_empty_flag    <= emp;
    rx_fifo_lost_flag     <= fl;
  endtask

  // Single exit point for every outcome, hangs included.
  task automatic results;
    $display("comparisons %0d mismatches %0d", comparisons, error_cnt);
    if (error_cnt == 0 && comparisons > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask

  ////////////////////////////////////////////////////////////////////////////
  // Watchdog: the whole sequence needs far fewer cycles than this.
  initial
  begin
    repeat (5000) @(posedge sys_clk);
    error_cnt++;
    results();
  end

  // Main sequence.
  initial
  begin
    sys_clk = 1'b0;
    rstn = 1'b0;
    bus_req = '0;
    mb_flags = '0;
    rx_fifo_empty_flag = 1'b1;
    rx_fifo_lost_flag = 1'b0;
    fifo_mailbox_mode_bit = 1'b0;
    error_cnt = 0;
    comparisons = 0;
    repeat (16) @(posedge sys_clk);
    rstn <= 1'b1;

    // Reset values, unmapped address and the read-only result offset.
    bus_rd(`CMS_OFS_MODE, 32'h0000_0000, "mode reset");
    bus_rd(`CMS_OFS_CHAN, 32'h0000_0000, "chan reset");
    bus_wr(`CMS_OFS_RESULT, 32'h0000_0005);
    bus_rd(`CMS_OFS_RESULT, EXH, "result idle");
    bus_rd(8'h0C, 32'h0000_0000, "unmapped");
    check("exh idle", 32'h1, {31'h0, search_exhausted_bit});
    for (int m = 3; m >= 0; m--)
    begin
      bus_wr(`CMS_OFS_MODE, m);
      bus_rd(`CMS_OFS_MODE, m, "mode readback");
      check("mode field", m, {30'h0, search_mode_field});
    end
    $display("test registers done");

    // Receive search: lowest first, repeat reads stable, clears move it on.
    setf(64'h0000_0000_0000_0028, '0, '0, 1'b0, 1'b1, 1'b0);
    bus_rd(`CMS_OFS_RESULT, 32'h0000_0003, "rx lowest");
    bus_rd(`CMS_OFS_RESULT, 32'h0000_0003, "rx reread");
    check("exh busy", 32'h0, {31'h0, search_exhausted_bit});
    setf(64'h0000_0000_0000_0020, '0, '0, 1'b0, 1'b1, 1'b0);
    bus_rd(`CMS_OFS_RESULT, 32'h0000_0005, "rx next");
    setf(64'h0400_0000_0000_0000, '0, '0, 1'b0, 1'b1, 1'b0);
    bus_rd(`CMS_OFS_RESULT, 32'h0000_003A, "rx normal 58");
    setf(64'h0400_0000_0000_0000, '0, '0, 1'b1, 1'b0, 1'b0);
    bus_rd(`CMS_OFS_RESULT, 32'h0000_003C, "rx fifo 60");
    setf(64'h0400_0000_0000_0000, '0, '0, 1'b1, 1'b1, 1'b0);
    bus_rd(`CMS_OFS_RESULT, EXH, "rx fifo empty");
    check("exh rx", 32'h1, {31'h0, search_exhausted_bit});
    $display("test receive done");

    // Transmit search: the transmit FIFO drops out in FIFO mode.
    bus_wr(`CMS_OFS_MODE, 32'h0000_0001);
    setf('0, 64'h8200_0100_0000_0000, '0, 1'b1, 1'b1, 1'b0);
    bus_rd(`CMS_OFS_RESULT, 32'h0000_0028, "tx lowest");
    setf('0, 64'h8200_0000_0000_0000, '0, 1'b0, 1'b1, 1'b0);
    bus_rd(`CMS_OFS_RESULT, 32'h0000_0039, "tx normal 57");
    setf('0, 64'h8200_0000_0000_0000, '0, 1'b1, 1'b1, 1'b0);
    bus_rd(`CMS_OFS_RESULT, EXH, "tx fifo skip");
    $display("test transmit done");

    // Lost search, ordinary flags and the receive FIFO lost flag.
    bus_wr(`CMS_OFS_MODE, 32'h0000_0002);
    setf('0, '0, 64'h2000_0000_0000_0400, 1'b0, 1'b1, 1'b1);
    bus_rd(`CMS_OFS_RESULT, 32'h0000_000A, "lost lowest");
    setf('0, '0, 64'h2000_0000_0000_0000, 1'b0, 1'b1, 1'b1);
    bus_rd(`CMS_OFS_RESULT, 32'h0000_003D, "lost normal 61");
    setf('0, '0, 64'h2000_0000_0000_0000, 1'b1, 1'b1, 1'b1);
    bus_rd(`CMS_OFS_RESULT, 32'h0000_003C, "lost fifo 60");
    setf('0, '0, 64'h2000_0000_0000_0000, 1'b1, 1'b1, 1'b0);
    bus_rd(`CMS_OFS_RESULT, EXH, "lost fifo clear");
    $display("test lost done");

    // Channel search: each read advances, with one idle cycle between reads.
    bus_wr(`CMS_OFS_MODE, 32'h0000_0003);
    bus_wr(`CMS_OFS_CHAN, 32'h0000_8005);
    bus_rd(`CMS_OFS_RESULT, 32'h0000_0000, "chan bit0");
    bus_rd(`CMS_OFS_RESULT, 32'h0000_0002, "chan bit2");
    bus_rd(`CMS_OFS_RESULT, 32'h0000_000F, "chan bit15");
    bus_rd(`CMS_OFS_RESULT, EXH, "chan empty");
    check("exh chan", 32'h1, {31'h0, search_exhausted_bit});
    $display("test channel done");

    // Reset in mid-run returns mode, vector and live flag to their idle values.
    bus_wr(`CMS_OFS_CHAN, 32'h0000_0003);
    @(posedge sys_clk);
    rstn <= 1'b0;
    repeat (2) @(posedge sys_clk);
    rstn <= 1'b1;
    bus_rd(`CMS_OFS_MODE, 32'h0000_0000, "mode after reset");
    bus_rd(`CMS_OFS_CHAN, 32'h0000_0000, "chan after reset");
    check("exh after reset", 32'h1, {31'h0, search_exhausted_bit});
    $display("test reset done");
    results();
  end
endmodule
